// ===== crf_core_regs.sv
/*
  Programmer-visible core state: accumulator, pointers, short-direct bytes,
  program counter, three context flag pairs and the return stack.
  Assumes the sequencer issues at most one program-counter action per
  machine cycle and never reads and writes the same byte in one cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module crf_core_regs
  import crf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic data_wr,
  input wire logic [7:0] data_addr,
  input wire logic [CRF_DATA_W-1:0] data_wdata,
  output logic [CRF_DATA_W-1:0] data_rdata_r,
  output logic data_hit_r,
  input wire logic fetch_adv,
  input wire logic jump_ld,
  input wire logic call_ld,
  input wire logic [CRF_PC_W-1:0] target_addr,
  input wire logic branch_ld,
  input wire logic [CRF_PC_W-1:0] alu_sum,
  input wire logic irq_take,
  input wire logic nmi_take,
  input wire logic [CRF_PC_W-1:0] vector_addr,
  input wire logic sub_exit,
  input wire logic handler_exit,
  input wire logic carry_wr,
  input wire logic carry_in,
  input wire logic zero_wr,
  input wire logic zero_in,
  output logic [CRF_PC_W-1:0] program_counter_r,
  output logic [CRF_PC_W-1:0] alu_pc_r,
  output logic active_carry_r,
  output logic active_zero_r,
  output logic [2:0] context_r,
  output logic [CRF_LVL_W-1:0] stack_level_r,
  output logic [CRF_DATA_W-1:0] sum_holder_r
);
  import crf_pkg::*;

  logic [CRF_DATA_W-1:0] pointer_first_r;
  logic [CRF_DATA_W-1:0] pointer_second_r;
  logic [CRF_DATA_W-1:0] short_slot_first_r;
  logic [CRF_DATA_W-1:0] short_slot_second_r;
  logic normal_carry_r;
  logic normal_zero_r;
  logic interrupt_carry_r;
  logic interrupt_zero_r;
  logic nonmaskable_carry_r;
  logic nonmaskable_zero_r;
  crf_ctx_t ctx_r;
  crf_ctx_t ctx_nxt;
  crf_ctx_t saved_ctx_r;
  crf_ctx_t saved_ctx2_r;
  crf_pc_src_t pc_src;
  logic [CRF_PC_W-1:0] program_counter_nxt;
  logic stk_push;
  logic stk_pop;
  logic stk_empty;
  logic [CRF_PC_W-1:0] stk_top;
  logic [CRF_LVL_W-1:0] stk_level;
  logic [CRF_DATA_W-1:0] rdata_nxt;
  logic hit_nxt;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == CRF_ADDR_ACC) || (a == CRF_ADDR_PTR0) || (a == CRF_ADDR_PTR1)
      || (a == CRF_ADDR_SLOT0) || (a == CRF_ADDR_SLOT1);
  endfunction

  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] t);
    wr_hit = wr && (a == t);
  endfunction

  // Data-space bytes; other addresses belong to other blocks
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sum_holder_r <= CRF_BYTE_RST;
    end else if (wr_hit(data_wr, data_addr, CRF_ADDR_ACC)) begin
      sum_holder_r <= data_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pointer_first_r <= CRF_BYTE_RST;
      pointer_second_r <= CRF_BYTE_RST;
    end else begin
      if (wr_hit(data_wr, data_addr, CRF_ADDR_PTR0)) begin
        pointer_first_r <= data_wdata;
      end
      if (wr_hit(data_wr, data_addr, CRF_ADDR_PTR1)) begin
        pointer_second_r <= data_wdata;
      end
    end
  end

  // Bit operations arrive as read-modify-write byte writes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      short_slot_first_r <= CRF_BYTE_RST;
      short_slot_second_r <= CRF_BYTE_RST;
    end else begin
      if (wr_hit(data_wr, data_addr, CRF_ADDR_SLOT0)) begin
        short_slot_first_r <= data_wdata;
      end
      if (wr_hit(data_wr, data_addr, CRF_ADDR_SLOT1)) begin
        short_slot_second_r <= data_wdata;
      end
    end
  end

  always_comb begin
    unique case (data_addr)
      CRF_ADDR_ACC: rdata_nxt = sum_holder_r;
      CRF_ADDR_PTR0: rdata_nxt = pointer_first_r;
      CRF_ADDR_PTR1: rdata_nxt = pointer_second_r;
      CRF_ADDR_SLOT0: rdata_nxt = short_slot_first_r;
      CRF_ADDR_SLOT1: rdata_nxt = short_slot_second_r;
      default: rdata_nxt = CRF_BYTE_RST;
    endcase
    hit_nxt = is_mapped(data_addr);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      data_rdata_r <= CRF_BYTE_RST;
      data_hit_r <= 1'b0;
    end else begin
      data_rdata_r <= rdata_nxt;
      data_hit_r <= hit_nxt;
    end
  end

  // Program counter source, highest priority first
  always_comb begin
    if (nmi_take || irq_take) begin
      pc_src = CRF_PC_VECTOR;
    end else if (jump_ld || call_ld) begin
      pc_src = CRF_PC_JUMP;
    end else if (branch_ld) begin
      pc_src = CRF_PC_BRANCH;
    end else if ((sub_exit || handler_exit) && !stk_empty) begin
      pc_src = CRF_PC_EXIT;
    end else if (fetch_adv || sub_exit || handler_exit) begin
      pc_src = CRF_PC_SEQ;
    end else begin
      pc_src = CRF_PC_HOLD;
    end
  end

  // Only twelve bits; bank switching lives in a separate register
  always_comb begin
    unique case (pc_src)
      CRF_PC_VECTOR: program_counter_nxt = vector_addr;
      CRF_PC_JUMP: program_counter_nxt = target_addr;
      CRF_PC_BRANCH: program_counter_nxt = alu_sum;
      CRF_PC_EXIT: program_counter_nxt = stk_top;
      CRF_PC_SEQ: program_counter_nxt = program_counter_r + CRF_PC_ONE;
      default: program_counter_nxt = program_counter_r;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      program_counter_r <= CRF_RESET_VECTOR;
    end else begin
      program_counter_r <= program_counter_nxt;
    end
  end

  // PC is offered to the ALU so branch sums share the adder
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      alu_pc_r <= CRF_RESET_VECTOR;
    end else begin
      alu_pc_r <= program_counter_nxt;
    end
  end

  // Return address is the counter value already advanced by the caller
  assign stk_push = call_ld || irq_take || nmi_take;
  assign stk_pop = (sub_exit || handler_exit) && !stk_push;
  assign stk_empty = (stk_level == CRF_LVL_EMPTY);

  crf_ret_stack u_stack (
    .ref_clk(ref_clk),
    .reset(reset),
    .push(stk_push),
    .pop(stk_pop),
    .push_data(program_counter_r),
    .top_r(stk_top),
    .level_r(stk_level)
  );

  // Context tracking; two saved levels cover main, irq and nmi nesting
  always_comb begin
    ctx_nxt = ctx_r;
    if (nmi_take) begin
      ctx_nxt = CRF_CTX_NMI;
    end else if (irq_take) begin
      ctx_nxt = CRF_CTX_IRQ;
    end else if (handler_exit) begin
      ctx_nxt = saved_ctx_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctx_r <= CRF_CTX_NMI;
      saved_ctx_r <= CRF_CTX_MAIN;
      saved_ctx2_r <= CRF_CTX_MAIN;
    end else begin
      ctx_r <= ctx_nxt;
      if (nmi_take || irq_take) begin
        saved_ctx_r <= ctx_r;
        saved_ctx2_r <= saved_ctx_r;
      end else if (handler_exit) begin
        saved_ctx_r <= saved_ctx2_r;
        saved_ctx2_r <= CRF_CTX_MAIN;
      end
    end
  end

  // Pairs are only written in their own context; switching touches none
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      normal_carry_r <= 1'b0;
      interrupt_carry_r <= 1'b0;
      nonmaskable_carry_r <= 1'b0;
    end else if (carry_wr) begin
      unique case (ctx_r)
        CRF_CTX_MAIN: normal_carry_r <= carry_in;
        CRF_CTX_IRQ: interrupt_carry_r <= carry_in;
        CRF_CTX_NMI: nonmaskable_carry_r <= carry_in;
        default: normal_carry_r <= normal_carry_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      normal_zero_r <= 1'b0;
      interrupt_zero_r <= 1'b0;
      nonmaskable_zero_r <= 1'b0;
    end else if (zero_wr) begin
      unique case (ctx_r)
        CRF_CTX_MAIN: normal_zero_r <= zero_in;
        CRF_CTX_IRQ: interrupt_zero_r <= zero_in;
        CRF_CTX_NMI: nonmaskable_zero_r <= zero_in;
        default: normal_zero_r <= normal_zero_r;
      endcase
    end
  end

  // Visible flags follow the next context so outputs stay registered
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      active_carry_r <= 1'b0;
      active_zero_r <= 1'b0;
      context_r <= CRF_CTX_NMI;
      stack_level_r <= CRF_LVL_EMPTY;
    end else begin
      unique case (ctx_nxt)
        CRF_CTX_MAIN: begin
          active_carry_r <= (carry_wr && ctx_r == CRF_CTX_MAIN) ? carry_in : normal_carry_r;
          active_zero_r <= (zero_wr && ctx_r == CRF_CTX_MAIN) ? zero_in : normal_zero_r;
        end
        CRF_CTX_IRQ: begin
          active_carry_r <= (carry_wr && ctx_r == CRF_CTX_IRQ) ? carry_in : interrupt_carry_r;
          active_zero_r <= (zero_wr && ctx_r == CRF_CTX_IRQ) ? zero_in : interrupt_zero_r;
        end
        default: begin
          active_carry_r <= (carry_wr && ctx_r == CRF_CTX_NMI) ? carry_in : nonmaskable_carry_r;
          active_zero_r <= (zero_wr && ctx_r == CRF_CTX_NMI) ? zero_in : nonmaskable_zero_r;
        end
      endcase
      context_r <= ctx_nxt;
      stack_level_r <= stk_push ? ((stk_level == CRF_LVL_FULL) ? stk_level : stk_level + 3'h1)
        : (stk_pop && !stk_empty) ? stk_level - 3'h1 : stk_level;
    end
  end

  a_acc_write: assert property (@(posedge ref_clk) disable iff (reset)
    data_wr && data_addr == CRF_ADDR_ACC |=> sum_holder_r == $past(data_wdata))
    else $error("accumulator write lost");
  a_acc_read: assert property (@(posedge ref_clk) disable iff (reset)
    !data_wr && data_addr == CRF_ADDR_ACC |=> data_rdata_r == sum_holder_r)
    else $error("accumulator read mismatch");
  a_ptr_read: assert property (@(posedge ref_clk) disable iff (reset)
    !data_wr && data_addr == CRF_ADDR_PTR1 |=> data_rdata_r == pointer_second_r)
    else $error("second pointer read mismatch");
  a_slot_write: assert property (@(posedge ref_clk) disable iff (reset)
    data_wr && data_addr == CRF_ADDR_SLOT0 |=> short_slot_first_r == $past(data_wdata))
    else $error("short slot write lost");
  a_slot_read: assert property (@(posedge ref_clk) disable iff (reset)
    !data_wr && data_addr == CRF_ADDR_SLOT1 |=> data_rdata_r == short_slot_second_r)
    else $error("second short slot read mismatch");
  a_pc_seq: assert property (@(posedge ref_clk) disable iff (reset)
    pc_src == CRF_PC_SEQ |=> program_counter_r == $past(program_counter_r) + CRF_PC_ONE)
    else $error("counter did not advance by one");
  a_pc_branch: assert property (@(posedge ref_clk) disable iff (reset)
    pc_src == CRF_PC_BRANCH |=> program_counter_r == $past(alu_sum))
    else $error("branch sum not loaded");
  a_pc_jump: assert property (@(posedge ref_clk) disable iff (reset)
    pc_src == CRF_PC_JUMP |=> program_counter_r == $past(target_addr))
    else $error("jump target not loaded");
  a_vector_load: assert property (@(posedge ref_clk) disable iff (reset)
    (nmi_take || irq_take) |=> program_counter_r == $past(vector_addr))
    else $error("interrupt vector not loaded");
  a_call_push: assert property (@(posedge ref_clk) disable iff (reset)
    call_ld && !nmi_take && !irq_take
    |=> program_counter_r == $past(target_addr) && stack_level_r != CRF_LVL_EMPTY)
    else $error("call did not load target and push");
  a_exit_pop: assert property (@(posedge ref_clk) disable iff (reset)
    pc_src == CRF_PC_EXIT |=> program_counter_r == $past(stk_top))
    else $error("return address not restored");
  a_exit_empty: assert property (@(posedge ref_clk) disable iff (reset)
    (sub_exit || handler_exit) && stk_empty && !stk_push && !jump_ld && !branch_ld
    |=> program_counter_r == $past(program_counter_r) + CRF_PC_ONE)
    else $error("exit on empty stack did not continue");
  a_reset_nmi: assert property (@(posedge ref_clk)
    reset |=> ctx_r == CRF_CTX_NMI && program_counter_r == CRF_RESET_VECTOR)
    else $error("reset did not select nmi context");
  a_switch_keep: assert property (@(posedge ref_clk) disable iff (reset)
    ctx_r != CRF_CTX_MAIN |=> normal_carry_r == $past(normal_carry_r))
    else $error("normal carry changed outside main");
  a_irq_pair_keep: assert property (@(posedge ref_clk) disable iff (reset)
    ctx_r != CRF_CTX_IRQ |=> interrupt_zero_r == $past(interrupt_zero_r))
    else $error("interrupt zero changed outside its context");
  a_nmi_pair_keep: assert property (@(posedge ref_clk) disable iff (reset)
    ctx_r != CRF_CTX_NMI |=> nonmaskable_carry_r == $past(nonmaskable_carry_r))
    else $error("nonmaskable carry changed outside its context");
  a_irq_ctx: assert property (@(posedge ref_clk) disable iff (reset)
    irq_take && !nmi_take |=> ctx_r == CRF_CTX_IRQ ##0 saved_ctx_r == $past(ctx_r))
    else $error("irq context not entered");
  a_nmi_ctx: assert property (@(posedge ref_clk) disable iff (reset)
    nmi_take |=> ctx_r == CRF_CTX_NMI && context_r == CRF_CTX_NMI)
    else $error("nmi context not entered");
  a_exit_ctx: assert property (@(posedge ref_clk) disable iff (reset)
    handler_exit && !irq_take && !nmi_take |=> ctx_r == $past(saved_ctx_r))
    else $error("previous context not restored");
  a_carry_write: assert property (@(posedge ref_clk) disable iff (reset)
    carry_wr && ctx_nxt == ctx_r |=> active_carry_r == $past(carry_in))
    else $error("active carry not written");
  a_zero_write: assert property (@(posedge ref_clk) disable iff (reset)
    zero_wr && ctx_nxt == ctx_r |=> active_zero_r == $past(zero_in))
    else $error("active zero not written");
endmodule
`default_nettype wire

// ===== crf_pkg.sv
/*
  Constants, types and data-space offsets for the core register file.
  Assumes a single machine clock and a synchronous, active-high chip reset.
*/
package crf_pkg;
  localparam int CRF_PC_W = 12;
  localparam int CRF_DATA_W = 8;
  localparam int CRF_DEPTH = 6;
  localparam int CRF_LVL_W = 3;
  localparam logic [7:0] CRF_ADDR_PTR0 = 8'h80;
  localparam logic [7:0] CRF_ADDR_PTR1 = 8'h81;
  localparam logic [7:0] CRF_ADDR_SLOT0 = 8'h82;
  localparam logic [7:0] CRF_ADDR_SLOT1 = 8'h83;
  localparam logic [7:0] CRF_ADDR_ACC = 8'hff;
  localparam logic [7:0] CRF_BYTE_RST = 8'h00;
  localparam logic [11:0] CRF_RESET_VECTOR = 12'hffe;
  localparam logic [11:0] CRF_PC_ONE = 12'h001;
  localparam logic [2:0] CRF_LVL_FULL = 3'h6;
  localparam logic [2:0] CRF_LVL_EMPTY = 3'h0;
  typedef enum logic [2:0] {
    CRF_CTX_MAIN = 3'b001,
    CRF_CTX_IRQ = 3'b010,
    CRF_CTX_NMI = 3'b100
  } crf_ctx_t;
  typedef enum logic [2:0] {
    CRF_PC_SEQ = 3'h0,
    CRF_PC_JUMP = 3'h1,
    CRF_PC_BRANCH = 3'h2,
    CRF_PC_VECTOR = 3'h3,
    CRF_PC_EXIT = 3'h4,
    CRF_PC_HOLD = 3'h5
  } crf_pc_src_t;
endpackage

// ===== crf_ret_stack.sv
/*
  Six-level return-address stack with saturating push and pop.
  Assumes push and pop are never requested together.
*/
`timescale 1ns/1ns
`default_nettype none
module crf_ret_stack
  import crf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic push,
  input wire logic pop,
  input wire logic [CRF_PC_W-1:0] push_data,
  output logic [CRF_PC_W-1:0] top_r,
  output logic [CRF_LVL_W-1:0] level_r
);
  import crf_pkg::*;
  logic [CRF_PC_W-1:0] ent_r [CRF_DEPTH];

  // Storage outside data space, no pointer exposed as an address
  always_ff @(posedge ref_clk) begin
    if (push) begin
      ent_r[0] <= push_data;
      for (int i = 1; i < CRF_DEPTH; i++) begin
        ent_r[i] <= ent_r[i-1];
      end
    end else if (pop) begin
      for (int i = 0; i < CRF_DEPTH-1; i++) begin
        ent_r[i] <= ent_r[i+1];
      end
    end
  end

  // Fill level only saturates; contents shift regardless
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      level_r <= CRF_LVL_EMPTY;
    end else if (push && level_r != CRF_LVL_FULL) begin
      level_r <= level_r + 3'h1;
    end else if (pop && level_r != CRF_LVL_EMPTY) begin
      level_r <= level_r - 3'h1;
    end
  end

  assign top_r = ent_r[0];

  a_push_level: assert property (@(posedge ref_clk) disable iff (reset)
    push && level_r == CRF_LVL_FULL |=> level_r == CRF_LVL_FULL)
    else $error("stack level left saturation on push");
  a_pop_empty: assert property (@(posedge ref_clk) disable iff (reset)
    pop && !push && level_r == CRF_LVL_EMPTY |=> level_r == CRF_LVL_EMPTY)
    else $error("stack level moved below empty");
  a_push_top: assert property (@(posedge ref_clk) disable iff (reset)
    push |=> top_r == $past(push_data))
    else $error("pushed address not at first level");
endmodule
`default_nettype wire

// ===== crf_alu_model.sv
/*
  Adder model of the sequencer ALU, as used for relative branches.
  Assumes the bench presents the offset as two's complement in counter width.
*/
`timescale 1ns/1ns
`default_nettype none
module crf_alu_model (
  input wire logic [crf_pkg::CRF_PC_W-1:0] pc_in,
  input wire logic [crf_pkg::CRF_PC_W-1:0] offset,
  output logic [crf_pkg::CRF_PC_W-1:0] sum
);
  import crf_pkg::*;
  // Combinational, so the sum is ready at the branch edge; wraps at 12 bits
  assign sum = pc_in + offset;
endmodule
`default_nettype wire

// ===== crf_core_regs_tb.sv
/*
  Self-checking bench for the core register file, with the ALU adder model.
  Assumes one 100 MHz machine clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module crf_core_regs_tb;
  import crf_pkg::*;
  localparam int k_pc = 0, k_acc = 1, k_rd = 2, k_hit = 3, k_c = 4;
  localparam int k_z = 5, k_ctx = 6, k_lvl = 7, k_apc = 8;
  localparam logic [10:0] f_wr = 11'h001, f_adv = 11'h002, f_jump = 11'h004;
  localparam logic [10:0] f_call = 11'h008, f_br = 11'h010, f_irq = 11'h020;
  localparam logic [10:0] f_nmi = 11'h040, f_sub = 11'h080, f_hdl = 11'h100;
  localparam logic [10:0] f_cw = 11'h200, f_zw = 11'h400;
  typedef struct {int due; int k; logic [11:0] v;} crf_note_t;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [10:0] ctl = 11'h000;
  logic [7:0] data_addr = 8'h00;
  logic [7:0] data_wdata = 8'h00;
  logic [11:0] tgt = 12'h000;
  logic cin = 1'b0;
  logic zin = 1'b0;
  logic [7:0] rdata, acc;
  logic hit, c_o, z_o;
  logic [11:0] pc, alu_pc, alu_sum;
  logic [2:0] ctx, lvl;
  crf_note_t notes[$];
  int ncyc = 0;
  int fails = 0;
  int num_checks = 0;
  int unsigned rnd;
  logic [11:0] exp_pc = CRF_RESET_VECTOR;
  logic [11:0] stk[$];
  logic [7:0] regv[5];
  logic [7:0] maddr[5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};

  always #5 ref_clk = ~ref_clk;

  crf_core_regs uut (
    .ref_clk(ref_clk), .reset(reset), .data_wr(ctl[0]), .data_addr(data_addr),
    .data_wdata(data_wdata), .data_rdata_r(rdata), .data_hit_r(hit),
    .fetch_adv(ctl[1]), .jump_ld(ctl[2]), .call_ld(ctl[3]), .target_addr(tgt),
    .branch_ld(ctl[4]), .alu_sum(alu_sum), .irq_take(ctl[5]), .nmi_take(ctl[6]),
    .vector_addr(tgt), .sub_exit(ctl[7]), .handler_exit(ctl[8]),
    .carry_wr(ctl[9]), .carry_in(cin), .zero_wr(ctl[10]), .zero_in(zin),
    .program_counter_r(pc), .alu_pc_r(alu_pc), .active_carry_r(c_o),
    .active_zero_r(z_o), .context_r(ctx), .stack_level_r(lvl), .sum_holder_r(acc)
  );

  crf_alu_model alu (.pc_in(alu_pc), .offset(tgt), .sum(alu_sum));

  task automatic note(input int k, input logic [11:0] v, input int d = 2);
    notes.push_back('{ncyc + d, k, v});
  endtask

  task automatic cmp_addr(input string n, input logic [11:0] e, input logic [11:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_state(input string n, input logic [2:0] e, input logic [2:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask

  // Results land one edge after the taking edge, so look half a cycle later
  always @(negedge ref_clk) begin
    ncyc = ncyc + 1;
    while (notes.size() > 0 && notes[0].due <= ncyc) begin
      case (notes[0].k)
        k_pc: cmp_addr("program_counter", notes[0].v, pc);
        k_apc: cmp_addr("alu_pc", notes[0].v, alu_pc);
        k_acc: cmp_byte("sum_holder", notes[0].v[7:0], acc);
        k_rd: cmp_byte("read_data", notes[0].v[7:0], rdata);
        k_hit: cmp_state("hit", notes[0].v[2:0], {2'b00, hit});
        k_c: cmp_state("carry", notes[0].v[2:0], {2'b00, c_o});
        k_z: cmp_state("zero", notes[0].v[2:0], {2'b00, z_o});
        k_ctx: cmp_state("context", notes[0].v[2:0], ctx);
        default: cmp_state("stack_level", notes[0].v[2:0], lvl);
      endcase
      void'(notes.pop_front());
    end
  end

  // One request per cycle; every pulse is rewritten each call, so none lingers
  task automatic op(input logic [10:0] c, input logic [7:0] a, input logic [7:0] d,
                    input logic [11:0] t);
    @(posedge ref_clk);
    ctl <= c;
    data_addr <= a;
    data_wdata <= d;
    tgt <= t;
    cin <= d[0];
    zin <= d[1];
    if (c & (f_irq | f_nmi | f_call)) begin
      stk.push_front(exp_pc);
      if (stk.size() > 6) void'(stk.pop_back());
    end
    if (c & (f_irq | f_nmi | f_jump | f_call)) exp_pc = t;
    else if (c & f_br) exp_pc = exp_pc + t;
    else if ((c & (f_sub | f_hdl)) && stk.size() > 0) exp_pc = stk.pop_front();
    else if (c & (f_adv | f_sub | f_hdl)) exp_pc = exp_pc + 12'h001;
    note(k_pc, exp_pc);
    note(k_apc, exp_pc);
    note(k_lvl, 12'(stk.size()));
  endtask

  task automatic flags(input logic [2:0] x, input logic c, input logic z);
    note(k_ctx, {9'h000, x});
    note(k_c, {11'h000, c});
    note(k_z, {11'h000, z});
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // About 40 requests are expected; ten thousand cycles leaves a wide margin
  initial begin
    #100000;
    fails++;
    wrap_up();
  end

  initial begin
    rnd = $urandom(32'h527c);
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    note(k_pc, CRF_RESET_VECTOR, 1);
    note(k_ctx, 12'h004, 1);
    note(k_lvl, 12'h000, 1);
    note(k_acc, 12'h000, 1);
    $display("test reset done");
    foreach (maddr[i]) begin
      regv[i] = 8'($urandom);
      op(f_wr, maddr[i], regv[i], 12'h000);
    end
    op(f_wr, 8'h84, 8'ha5, 12'h000);
    // Last pass reads the unmapped byte just written
    for (int i = 0; i < 6; i++) begin
      op(11'h000, (i < 5) ? maddr[i] : 8'h84, 8'h00, 12'h000);
      note(k_rd, (i < 5) ? {4'h0, regv[i]} : 12'h000);
      note(k_hit, (i < 5) ? 12'h001 : 12'h000);
    end
    note(k_acc, {4'h0, regv[4]});
    $display("test data space done");
    op(f_adv, 8'h00, 8'h00, 12'h000);
    op(f_adv, 8'h00, 8'h00, 12'h000);
    op(f_jump, 8'h00, 8'h00, 12'h123);
    op(f_br, 8'h00, 8'h00, 12'h010);
    op(f_br, 8'h00, 8'h00, 12'hffd);
    $display("test program counter done");
    // Seven calls overrun the six levels; seven exits end on an empty stack
    for (int i = 0; i < 7; i++) op(f_call, 8'h00, 8'h00, 12'($urandom));
    for (int i = 0; i < 7; i++) op(f_sub, 8'h00, 8'h00, 12'h000);
    note(k_acc, {4'h0, regv[4]});
    $display("test return stack done");
    op(f_cw | f_zw, 8'h00, 8'h01, 12'h000);
    flags(3'h4, 1'b1, 1'b0);
    op(f_hdl, 8'h00, 8'h00, 12'h000);
    flags(3'h1, 1'b0, 1'b0);
    op(f_cw | f_zw, 8'h00, 8'h02, 12'h000);
    flags(3'h1, 1'b0, 1'b1);
    op(f_irq, 8'h00, 8'h00, 12'h004);
    flags(3'h2, 1'b0, 1'b0);
    op(f_cw | f_zw, 8'h00, 8'h03, 12'h000);
    flags(3'h2, 1'b1, 1'b1);
    op(f_nmi, 8'h00, 8'h00, 12'h008);
    flags(3'h4, 1'b1, 1'b0);
    op(f_hdl, 8'h00, 8'h00, 12'h000);
    flags(3'h2, 1'b1, 1'b1);
    op(f_hdl, 8'h00, 8'h00, 12'h000);
    flags(3'h1, 1'b0, 1'b1);
    op(11'h000, 8'h00, 8'h00, 12'h000);
    $display("test flag contexts done");
    repeat (3) @(negedge ref_clk);
    wrap_up();
  end
endmodule
`default_nettype wire
